// file: src/ssc_defines.svh
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH
`define SSC_CTRL       8'h00
`define SSC_CFG_SEL    8'h04
`define SSC_CHAN_EN    8'h08
`define SSC_LIM_MASK   8'h0C
`define SSC_SAT_MASK   8'h10
`define SSC_EOS_MASK   8'h14
`define SSC_LOW        8'h18
`define SSC_HIGH       8'h1C
`define SSC_CMP_MODE   8'h20
`define SSC_EOC        8'h24
`define SSC_INTERRUPT_FLAG_REGISTER       8'h28
`define SSC_LIM_STAT   8'h2C
`define SSC_SAT_STAT   8'h30
`define SSC_RESULT     8'h40
`define SSC_B_MODE     0
`define SSC_B_START    1
`define SSC_B_STOP     2
`define SSC_B_SHDN     3
`define SSC_B_PWRUP    4
`define SSC_B_IRQEN    5
`define SSC_B_BUSY     6
`define SSC_B_OFF      7
`define SSC_B_RESTART  8
`define SSC_B_EOS      0
`define SSC_LOW_RST    16'h0200
`define SSC_HIGH_RST   16'h0E00
`define SSC_CHEN_RST   32'h0000_0003
`define SSC_SAT_MIN    16'h8000
`define SSC_SAT_MAX    16'h7FFF
`endif

// file: src/ssc_pkg.sv
package ssc_pkg;
  typedef enum logic [2:0] {
    ST_OFF  = 3'b001,
    ST_IDLE = 3'b010,
    ST_CONV = 3'b100
  } ssc_state_e;
  typedef enum logic [1:0] {
    CMP_BELOW   = 2'h0,
    CMP_INSIDE  = 2'h1,
    CMP_ABOVE   = 2'h2,
    CMP_OUTSIDE = 2'h3
  } ssc_cmp_e;
  typedef struct packed {
    logic        done;
    logic [15:0] raw;
    logic [15:0] fin;
  } ssc_conv_s;
endpackage : ssc_pkg

// file: src/ssc_result_mem.sv
`timescale 1ns/1ps
`default_nettype none
module ssc_result_mem #(
  parameter int W  = 16,
  parameter int D  = 17,
  parameter int AW = 5
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);
  logic [W-1:0] mem [D];

  always_ff @(posedge hclk) begin
    if (we && (32'(waddr) < D)) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata <= '0;
    end else if (32'(raddr) < D) begin
      rdata <= mem[raddr];
    end else begin
      rdata <= '0;
    end
  end
endmodule : ssc_result_mem
`default_nettype wire

// file: src/ssc_limit_cmp.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssc_defines.svh"
module ssc_limit_cmp (
  input  wire logic            [15:0] fin,
  input  wire logic            [15:0] raw,
  input  wire logic            [15:0] low,
  input  wire logic            [15:0] high,
  input  wire ssc_pkg::ssc_cmp_e      mode,
  output logic                        hit,
  output logic                        sat
);
  import ssc_pkg::*;
  logic below;
  logic above;

  // Signed compare on the final 16-bit result [RULE18]
  assign below = $signed(fin) < $signed(low);
  assign above = $signed(fin) >= $signed(high);
  // Raw value before averaging at either end of its range [RULE19]
  assign sat = (raw == `SSC_SAT_MIN) || (raw == `SSC_SAT_MAX);

  always_comb begin
    unique case (mode)
      CMP_BELOW:   hit = below;  // [RULE17]
      CMP_INSIDE:  hit = !below && !above;  // [RULE17]
      CMP_ABOVE:   hit = above;  // [RULE17]
      CMP_OUTSIDE: hit = below || above;  // [RULE17]
    endcase
  end
endmodule : ssc_limit_cmp
`default_nettype wire

// file: src/ssc_top.sv
// Operation
// [RULE1] Single-scan: one full scan per trigger edge
// [RULE2] Repeating: scan back to back while trigger high
// [RULE3] Stop: finish current work, start nothing more
// [RULE4] Stop completes scan; end visible in status
// [RULE5] Shutdown halts and enters lowest power
// [RULE6] Firmware should prefer stop over shutdown
// [RULE7] End-of-scan mask bit gates its interrupt
// [RULE8] Per-channel enable mask selects scanned channels
// [RULE9] End-of-conversion status, cleared on read
// [RULE10] One result per channel, injection at NCH
// [RULE11] Results read as signed 16-bit values
// [RULE12] Writable global low and high thresholds
// [RULE13] Per-channel limit mask gates limit flags
// [RULE14] Per-channel saturation mask gates saturation flags
// [RULE15] Interrupt enable gates the request output
// [RULE16] Config select reloads mode, optional restart
// [RULE17] Compare below, inside, above or outside
// [RULE18] Compare uses final 16-bit result format
// [RULE19] Saturation from raw value at range ends
// [RULE20] Request high while any unmasked flag pends
//
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "ssc_defines.svh"
module ssc_top #(
  parameter int         NCH      = 16,
  parameter logic [3:0] CFG_MODE = 4'h0
) (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic                            hreadyout,
  output logic      [31:0]                hrdata,
  output logic                            hresp,
  input  wire logic                       soc,
  input  wire ssc_pkg::ssc_conv_s         conv,
  output logic                            conv_start,
  output logic      [$clog2(NCH+1)-1:0]   conv_chan,
  output logic                            pwr_dn,
  output logic                            busy,
  output logic                            irq
);
  import ssc_pkg::*;
  localparam int NC = NCH + 1;
  localparam int CW = $clog2(NC);

  ssc_state_e      st;
  logic            acc;
  logic            dph;
  logic            dwr;
  logic [7:0]      daddr;
  logic            wr;
  logic            rd;
  logic [31:0]     next_rdata;
  logic [5:0]      ridx;
  logic [15:0]     mem_rdata;
  logic            mode;
  logic            irq_en;
  logic [NC-1:0]   chan_en;
  logic [NC-1:0]   chen_q;
  logic [NC-1:0]   lim_mask;
  logic [NC-1:0]   sat_mask;
  logic            eos_mask;
  logic [15:0]     low;
  logic [15:0]     high;
  ssc_cmp_e        cmp_mode;
  logic            eoc;
  logic            end_of_scan_flag;
  logic [NC-1:0]   lim_stat;
  logic [NC-1:0]   sat_stat;
  logic            soc_q;
  logic            trig_pend;
  logic            sw_run;
  logic            halt;
  logic            run_lvl;
  logic            go;
  logic            scan_end;
  logic            scan_begin;
  logic            res_we;
  logic            hit;
  logic            sat;
  logic            first_ok;
  logic [CW-1:0]   first_ch;
  logic            nxt_ok;
  logic [CW-1:0]   nxt_ch;
  logic            ctrl_w;
  logic            shdn_w;
  logic            start_w;
  logic            stop_w;
  logic            cfg_w;

  function automatic logic [CW:0] find_ch(input logic [NC-1:0] en, input int from);
    logic [CW:0] r;
    r = '0;
    for (int i = NC - 1; i >= 0; i--) begin
      if (en[i] && i >= from) begin
        r = {1'b1, CW'(i)};
      end
    end
    return r;
  endfunction : find_ch

  // Bus: every transfer takes one wait state so read data leave a flop
  assign acc = hsel && htrans[1] && hready;
  assign wr  = dph && dwr;
  assign rd  = dph && !dwr;
  assign ridx = haddr[7:2] - 6'h10;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph       <= 1'b0;
      dwr       <= 1'b0;
      daddr     <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dph       <= acc;
      hreadyout <= !acc;
      hresp     <= 1'b0;
      if (acc) begin
        dwr   <= hwrite;
        daddr <= haddr[7:0];
      end
    end
  end

  assign ctrl_w  = wr && daddr == `SSC_CTRL;
  assign shdn_w  = ctrl_w && hwdata[`SSC_B_SHDN];
  assign start_w = ctrl_w && hwdata[`SSC_B_START];
  assign stop_w  = ctrl_w && hwdata[`SSC_B_STOP];
  assign cfg_w   = wr && daddr == `SSC_CFG_SEL;

  // Mode: a config select discards any runtime override [RULE16]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode   <= 1'b0;
      irq_en <= 1'b0;
    end else if (cfg_w) begin
      mode <= CFG_MODE[hwdata[1:0]];  // [RULE16]
    end else if (ctrl_w) begin
      mode   <= hwdata[`SSC_B_MODE];
      irq_en <= hwdata[`SSC_B_IRQEN];  // [RULE15]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_en  <= NC'(`SSC_CHEN_RST);
      lim_mask <= '0;
      sat_mask <= '0;
      eos_mask <= 1'b0;
      low      <= `SSC_LOW_RST;
      high     <= `SSC_HIGH_RST;
      cmp_mode <= CMP_BELOW;
    end else if (wr) begin
      case (daddr)
        `SSC_CHAN_EN:  chan_en  <= hwdata[NC-1:0];  // [RULE8]
        `SSC_LIM_MASK: lim_mask <= hwdata[NC-1:0];  // [RULE13]
        `SSC_SAT_MASK: sat_mask <= hwdata[NC-1:0];  // [RULE14]
        `SSC_EOS_MASK: eos_mask <= hwdata[0];  // [RULE7]
        `SSC_LOW:      low      <= hwdata[15:0];  // [RULE12]
        `SSC_HIGH:     high     <= hwdata[15:0];  // [RULE12]
        `SSC_CMP_MODE: cmp_mode <= ssc_cmp_e'(hwdata[1:0]);
        default: ;
      endcase
    end
  end

  // Trigger: edge arms one scan, level keeps scans going
  assign run_lvl = soc || sw_run;
  assign go      = !halt && (mode ? run_lvl : trig_pend);  // [RULE1] [RULE2]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      soc_q     <= 1'b0;
      trig_pend <= 1'b0;
      sw_run    <= 1'b0;
      halt      <= 1'b0;
    end else begin
      soc_q <= soc;
      if (stop_w || shdn_w) begin
        halt      <= 1'b1;  // [RULE3]
        trig_pend <= 1'b0;
        sw_run    <= 1'b0;
      end else if (start_w || (cfg_w && hwdata[`SSC_B_RESTART])) begin
        halt      <= 1'b0;
        trig_pend <= 1'b1;  // [RULE16]
        sw_run    <= 1'b1;
      end else if (!mode && soc && !soc_q && !halt) begin
        trig_pend <= 1'b1;  // [RULE1]
      end else if (scan_begin) begin
        trig_pend <= 1'b0;  // [RULE1]
      end
    end
  end

  assign {first_ok, first_ch} = find_ch(chan_en, 0);
  assign {nxt_ok, nxt_ch}     = find_ch(chan_en, 32'(conv_chan) + 1);
  assign scan_begin = st == ST_IDLE && go && !shdn_w;
  assign res_we     = st == ST_CONV && conv.done;
  assign scan_end   = res_we && !nxt_ok;

  // Sequencer; disabled channels cost no time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st         <= ST_IDLE;
      conv_start <= 1'b0;
      conv_chan  <= '0;
      pwr_dn     <= 1'b0;
      busy       <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      if (shdn_w) begin
        st     <= ST_OFF;  // [RULE5]
        pwr_dn <= 1'b1;  // [RULE5]
        busy   <= 1'b0;
      end else begin
        unique case (st)
          ST_OFF: begin
            if (ctrl_w && hwdata[`SSC_B_PWRUP]) begin
              st     <= ST_IDLE;
              pwr_dn <= 1'b0;
            end
          end
          ST_IDLE: begin
            if (scan_begin && first_ok) begin
              st         <= ST_CONV;
              conv_chan  <= first_ch;  // [RULE8]
              conv_start <= 1'b1;
              busy       <= 1'b1;
            end
          end
          ST_CONV: begin
            if (res_we && nxt_ok) begin
              conv_chan  <= nxt_ch;  // [RULE4]
              conv_start <= 1'b1;
            end else if (res_we && go && mode && first_ok) begin
              conv_chan  <= first_ch;  // [RULE2]
              conv_start <= 1'b1;
            end else if (res_we) begin
              st   <= ST_IDLE;  // [RULE3] [RULE4]
              busy <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  ssc_limit_cmp u_cmp (
    .fin  (conv.fin),
    .raw  (conv.raw),
    .low  (low),
    .high (high),
    .mode (cmp_mode),
    .hit  (hit),
    .sat  (sat)
  );

  ssc_result_mem #(
    .W  (16),
    .D  (NC),
    .AW (CW)
  ) u_mem (
    .hclk    (hclk),
    .hresetn (hresetn),
    .we      (res_we),  // [RULE10]
    .waddr   (conv_chan),
    .wdata   (conv.fin),
    .raddr   (ridx[CW-1:0]),
    .rdata   (mem_rdata)
  );

  // Status flags: a set in the clearing cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eoc <= 1'b0;
    end else if (scan_end) begin
      eoc <= 1'b1;  // [RULE9] [RULE4]
    end else if ((rd && daddr == `SSC_EOC) || scan_begin) begin
      eoc <= 1'b0;  // [RULE9]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      end_of_scan_flag <= 1'b0;
    end else if (scan_end) begin
      end_of_scan_flag <= 1'b1;
    end else if (wr && daddr == `SSC_INTERRUPT_FLAG_REGISTER && hwdata[`SSC_B_EOS]) begin
      end_of_scan_flag <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lim_stat <= '0;
      sat_stat <= '0;
    end else begin
      for (int i = 0; i < NC; i++) begin
        if (res_we && 32'(conv_chan) == i && hit && lim_mask[i]) begin
          lim_stat[i] <= 1'b1;  // [RULE13]
        end else if (wr && daddr == `SSC_LIM_STAT && hwdata[i]) begin
          lim_stat[i] <= 1'b0;
        end
        if (res_we && 32'(conv_chan) == i && sat && sat_mask[i]) begin
          sat_stat[i] <= 1'b1;  // [RULE14]
        end else if (wr && daddr == `SSC_SAT_STAT && hwdata[i]) begin
          sat_stat[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq    <= 1'b0;
      chen_q <= '0;
    end else begin
      chen_q <= chan_en;
      irq    <= irq_en && ((end_of_scan_flag && eos_mask) || |(lim_stat & lim_mask)
                || |(sat_stat & sat_mask));  // [RULE7] [RULE15] [RULE20]
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (daddr)
      `SSC_CTRL: next_rdata = {24'h0, pwr_dn, busy, irq_en, 4'h0, mode};
      `SSC_CHAN_EN:  next_rdata = 32'(chan_en);
      `SSC_LIM_MASK: next_rdata = 32'(lim_mask);
      `SSC_SAT_MASK: next_rdata = 32'(sat_mask);
      `SSC_EOS_MASK: next_rdata = {31'h0, eos_mask};
      `SSC_LOW:      next_rdata = {16'h0, low};
      `SSC_HIGH:     next_rdata = {16'h0, high};
      `SSC_CMP_MODE: next_rdata = {30'h0, cmp_mode};
      `SSC_EOC:      next_rdata = {31'h0, eoc};  // [RULE9]
      `SSC_INTERRUPT_FLAG_REGISTER:     next_rdata = {31'h0, end_of_scan_flag};
      `SSC_LIM_STAT: next_rdata = 32'(lim_stat);
      `SSC_SAT_STAT: next_rdata = 32'(sat_stat);
      default: begin
        if (daddr >= `SSC_RESULT && daddr <= 8'(`SSC_RESULT + 4 * NCH)) begin
          next_rdata = {{16{mem_rdata[15]}}, mem_rdata};  // [RULE11]
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd) begin
      hrdata <= next_rdata;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  single_idle_a: assert property (st == ST_IDLE && !mode && !trig_pend |=> !conv_start) // [RULE1]
    else $error("single mode launched without trigger");
  repeat_level_a: assert property (st == ST_IDLE && mode && run_lvl && !halt && first_ok
    && !shdn_w |=> conv_start && conv_chan == $past(first_ch)) // [RULE2]
    else $error("repeating mode failed to launch");
  stop_quiet_a: assert property (st == ST_IDLE && halt
    |=> !conv_start ##1 (!conv_start || !$past(halt))) // [RULE3]
    else $error("conversion launched after stop");
  scan_end_eoc_a: assert property (scan_end |=> eoc && st != ST_CONV || conv_start) // [RULE4]
    else $error("scan end not reported");
  shutdown_off_a: assert property (shdn_w |=> pwr_dn && st == ST_OFF && !conv_start) // [RULE5]
    else $error("shutdown not entered");
  eos_masked_a: assert property (!eos_mask && lim_stat == '0 && sat_stat == '0
    |=> !irq) // [RULE7]
    else $error("masked interrupt raised");
  chan_enabled_a: assert property (conv_start |-> chen_q[conv_chan]) // [RULE8]
    else $error("disabled channel converted");
  eoc_clear_a: assert property (rd && daddr == `SSC_EOC && !scan_end |=> !eoc) // [RULE9]
    else $error("end of conversion not cleared by read");
  lim_gate_a: assert property ((lim_stat & ~$past(lim_stat) & ~$past(lim_mask)) == '0) // [RULE13]
    else $error("masked channel set limit flag");
  irq_pend_a: assert property (irq_en && |(lim_stat & lim_mask) |=> irq) // [RULE20]
    else $error("pending limit flag gave no request");

  scan_single_c: cover property (!mode && scan_begin ##[1:200] scan_end);
  scan_repeat_c: cover property (mode && scan_end ##[1:200] scan_end);
  stop_scan_c:   cover property (stop_w && st == ST_CONV ##[1:200] st == ST_IDLE);
  shutdown_c:    cover property (shdn_w ##[1:50] ctrl_w && hwdata[`SSC_B_PWRUP]);
endmodule : ssc_top
`default_nettype wire

// file: test/ssc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssc_defines.svh"
module ssc_top_bench;
  import ssc_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  wire  logic  hready;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        soc = 1'b0;
  ssc_conv_s   conv = '0;
  logic        conv_start;
  logic [2:0]  conv_chan;
  logic        pwr_dn;
  logic        busy;
  logic        irq;
  int          n_fail = 0;
  int          n_compared = 0;
  int          n_conv = 0;
  logic [2:0]  cur = 3'h0;
  logic [3:0]  cdown = 4'h0;
  logic [4:0]  chen = 5'h03;
  logic [31:0] rv;
  int          n0;
  // Distinct values per channel so a misplaced result shows up
  logic [15:0] fin_tab [0:4] = '{16'hFF00, 16'h0500, 16'h0F00, 16'h0000, 16'h0123};
  logic [15:0] raw_tab [0:4] = '{16'h8000, 16'h1234, 16'h1234, 16'h1234, 16'h1234};
  assign hready = hreadyout;
  ssc_top #(.NCH(4), .CFG_MODE(4'h2)) u_ssc_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .soc(soc), .conv(conv),
    .conv_start(conv_start), .conv_chan(conv_chan), .pwr_dn(pwr_dn), .busy(busy), .irq(irq)
  );
  initial begin
    forever #50 hclk = ~hclk;
  end
  // Converter core stand-in: one done per start, three cycles later
  always @(posedge hclk) begin
    conv.done <= 1'b0;
    if (conv_start === 1'b1) begin
      n_conv <= n_conv + 1;
      cur <= conv_chan;
      cdown <= 4'h3;
      chk("conv_chan_en", 32'h1, {31'h0, chen[conv_chan]});
    end else if (cdown == 4'h1) begin
      conv.done <= 1'b1;
      conv.fin <= fin_tab[cur];
      conv.raw <= raw_tab[cur];
      cdown <= 4'h0;
    end else if (cdown != 4'h0) begin
      cdown <= cdown - 4'h1;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared = n_compared + 1;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      n_fail = n_fail + 1;
    end
  endtask : chk
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rv = hrdata;
    hsel <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0000_0000);
    chk(nm, e, rv);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : rd_chk
  task automatic wait_idle();
    int i;
    repeat (3) @(posedge hclk);
    i = 0;
    while (busy !== 1'b0 && i < 500) begin
      @(posedge hclk);
      i++;
    end
    chk("busy", 32'h0, {31'h0, busy});
  endtask : wait_idle
  task automatic soc_scan(input int hold);
    @(posedge hclk);
    soc <= 1'b1;
    repeat (hold) @(posedge hclk);
    soc <= 1'b0;
    wait_idle();
  endtask : soc_scan
  task automatic t_reset();
    rd_chk("chan_en", `SSC_CHAN_EN, 32'h0000_0003);
    rd_chk("low", `SSC_LOW, 32'h0000_0200);
    rd_chk("high", `SSC_HIGH, 32'h0000_0E00);
    rd_chk("unmapped", 8'h3C, 32'h0000_0000);
    wr(`SSC_LOW, 32'h0000_0201);
    rd_chk("low_wr", `SSC_LOW, 32'h0000_0201);
    wr(`SSC_LOW, 32'h0000_0200);
    $display("test reset done");
  endtask : t_reset
  task automatic t_single();
    chen = 5'h15;
    wr(`SSC_CHAN_EN, 32'h0000_0015);
    // Flags are latched only for channels whose mask bit is set
    wr(`SSC_SAT_MASK, 32'h0000_0001);
    n0 = n_conv;
    soc_scan(30);
    chk("single_convs", 32'd3, n_conv - n0);
    rd_chk("eoc_set", `SSC_EOC, 32'h0000_0001);
    rd_chk("eoc_clr", `SSC_EOC, 32'h0000_0000);
    rd_chk("result0", `SSC_RESULT, 32'hFFFF_FF00);
    rd_chk("result2", `SSC_RESULT + 8'h08, 32'h0000_0F00);
    rd_chk("result4", `SSC_RESULT + 8'h10, 32'h0000_0123);
    rd_chk("sat_stat", `SSC_SAT_STAT, 32'h0000_0001);
    $display("test single done");
  endtask : t_single
  task automatic t_compare();
    logic [31:0] exp_lim [0:3];
    exp_lim = '{32'h1, 32'h2, 32'h4, 32'h5};
    chen = 5'h07;
    wr(`SSC_CHAN_EN, 32'h0000_0007);
    wr(`SSC_LIM_MASK, 32'h0000_0007);
    for (int m = 0; m < 4; m++) begin
      wr(`SSC_CMP_MODE, m);
      soc_scan(30);
      rd_chk("lim_stat", `SSC_LIM_STAT, exp_lim[m]);
      wr(`SSC_LIM_STAT, 32'h0000_001F);
    end
    $display("test compare done");
  endtask : t_compare
  task automatic t_irq();
    wr(`SSC_SAT_STAT, 32'h0000_001F);
    wr(`SSC_INTERRUPT_FLAG_REGISTER, 32'h0000_0001);
    wr(`SSC_EOS_MASK, 32'h0000_0001);
    soc_scan(30);
    chk("irq_off", 32'h0, {31'h0, irq});
    wr(`SSC_CTRL, 32'h0000_0020);
    repeat (2) @(posedge hclk);
    chk("irq_eos", 32'h1, {31'h0, irq});
    wr(`SSC_INTERRUPT_FLAG_REGISTER, 32'h0000_0001);
    wr(`SSC_EOS_MASK, 32'h0000_0000);
    wr(`SSC_SAT_MASK, 32'h0000_0002);
    wr(`SSC_LIM_MASK, 32'h0000_0002);
    soc_scan(30);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(`SSC_SAT_MASK, 32'h0000_0001);
    repeat (2) @(posedge hclk);
    chk("irq_sat", 32'h1, {31'h0, irq});
    wr(`SSC_SAT_STAT, 32'h0000_001F);
    repeat (2) @(posedge hclk);
    chk("irq_sat_clr", 32'h0, {31'h0, irq});
    wr(`SSC_LIM_MASK, 32'h0000_0001);
    repeat (2) @(posedge hclk);
    chk("irq_lim", 32'h1, {31'h0, irq});
    wr(`SSC_LIM_STAT, 32'h0000_001F);
    repeat (2) @(posedge hclk);
    chk("irq_lim_clr", 32'h0, {31'h0, irq});
    wr(`SSC_CTRL, 32'h0000_0000);
    $display("test irq done");
  endtask : t_irq
  task automatic wait_convs(input int n);
    int i;
    i = 0;
    while (n_conv < n && i < 500) begin
      @(posedge hclk);
      i++;
    end
  endtask : wait_convs
  task automatic t_repeat();
    chen = 5'h05;
    wr(`SSC_CHAN_EN, 32'h0000_0005);
    wr(`SSC_CTRL, 32'h0000_0001);
    n0 = n_conv;
    soc_scan(60);
    chk("rep_many", 32'h1, {31'h0, (n_conv - n0) >= 6});
    chk("rep_whole", 32'h0, (n_conv - n0) % 2);
    // Software run, then stop in mid-scan: the scan must still finish
    n0 = n_conv;
    wr(`SSC_CTRL, 32'h0000_0003);
    wait_convs(n0 + 3);
    wr(`SSC_CTRL, 32'h0000_0005);
    wait_idle();
    chk("stop_whole", 32'h0, (n_conv - n0) % 2);
    rd_chk("stop_eoc", `SSC_EOC, 32'h0000_0001);
    n0 = n_conv;
    repeat (30) @(posedge hclk);
    chk("stop_quiet", 32'h0, n_conv - n0);
    $display("test repeat done");
  endtask : t_repeat
  task automatic t_shutdown();
    wr(`SSC_CTRL, 32'h0000_0003);
    wait_convs(n_conv + 1);
    wr(`SSC_CTRL, 32'h0000_0008);
    repeat (2) @(posedge hclk);
    chk("pwr_dn", 32'h1, {31'h0, pwr_dn});
    chk("sd_busy", 32'h0, {31'h0, busy});
    rd_chk("ctrl_off", `SSC_CTRL, 32'h0000_0080);
    n0 = n_conv;
    repeat (30) @(posedge hclk);
    chk("sd_quiet", 32'h0, n_conv - n0);
    wr(`SSC_CTRL, 32'h0000_0010);
    repeat (2) @(posedge hclk);
    chk("pwr_up", 32'h0, {31'h0, pwr_dn});
    $display("test shutdown done");
  endtask : t_shutdown
  task automatic t_config();
    wr(`SSC_CFG_SEL, 32'h0000_0001);
    rd_chk("cfg1_mode", `SSC_CTRL, 32'h0000_0001);
    wr(`SSC_CFG_SEL, 32'h0000_0000);
    rd_chk("cfg0_mode", `SSC_CTRL, 32'h0000_0000);
    // Runtime override, then a config whose index low bit differs from its mode
    wr(`SSC_CTRL, 32'h0000_0001);
    wr(`SSC_CFG_SEL, 32'h0000_0003);
    rd_chk("cfg3_mode", `SSC_CTRL, 32'h0000_0000);
    n0 = n_conv;
    wr(`SSC_CFG_SEL, 32'h0000_0101);
    wait_convs(n0 + 4);
    chk("restart", 32'h1, {31'h0, (n_conv - n0) >= 4});
    wr(`SSC_CTRL, 32'h0000_0005);
    wait_idle();
    $display("test config done");
  endtask : t_config
  task automatic summarize();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  initial begin
    // Whole run is about a thousand cycles; this leaves wide margin
    repeat (30000) @(posedge hclk);
    $display("BAD watchdog exp finish got timeout");
    n_fail = n_fail + 1;
    summarize();
  end
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_single();
    t_compare();
    t_irq();
    t_repeat();
    t_shutdown();
    t_config();
    summarize();
  end
endmodule : ssc_top_bench
`default_nettype wire
